// *** verilog/timer_map.svh ***
// Register indices, field positions, reset values and timing counts
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_W 12
`define IDX_COUNT_LOW 12'hFD2
`define IDX_COUNT_HIGH 12'hFD3
`define IDX_CTRL_ZERO 12'hFD4
`define IDX_CTRL_ONE 12'hFD5
`define IDX_IRQ_STATUS 12'hFD6
`define IDX_IRQ_MASK 12'hFD7

// ==========================================================
// Field positions of control register zero
`define C0_RUN_BIT 7
`define C0_OUT_BIT 5
`define C0_WIDE_BIT 4
`define C0_DIV_MSB 3
`define C0_DIV_LSB 0

// ==========================================================
// Field positions of control register one
`define C1_SRC_MSB 7
`define C1_SRC_LSB 5
`define C1_BYPASS_BIT 4
`define C1_PRE_MSB 3
`define C1_PRE_LSB 0

// ==========================================================
// Reset values and timing
`define CTRL_RESET 8'h00
`define COUNT_RESET 8'h00
`define CLK_PERIOD_NS 4
`define INSTR_RATIO 4
`define INSTR_LAST 2'h3
`define PRE_CNT_W 15
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** verilog/timer_pkg.sv ***
// Types shared by the timer control block
package timer_pkg;

    // Count source codes of control register one
    typedef enum logic [2:0] {
        SRC_PIN = 3'b000,
        SRC_PIN_INV = 3'b001,
        SRC_INSTR = 3'b010,
        SRC_OSC_A = 3'b011,
        SRC_OSC_B = 3'b100,
        SRC_OSC_C = 3'b101,
        SRC_OSC_D = 3'b110,
        SRC_LOGIC = 3'b111
    } count_src_t;

endpackage

// *** verilog/input_filter.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module input_filter #(
    parameter int W = 6
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [W-1:0] raw_in, // Levels from outside the domain
    output logic [W-1:0] level_out // Filtered levels
);

    initial begin
        if (W < 1) begin
            $error("input_filter: W must be at least 1");
        end
    end

    // ==========================================================
    // Synchroniser chains, one per input
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : gen_chain
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // Stage one feeds stage two only; metastability hazard
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= raw_in[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q; // Change counts once stages agree
                    end
                end
            end
            assign level_out[g] = lvl_q;
        end
    endgenerate

endmodule

// *** verilog/timer_control_registers.sv ***
// Timer control registers, prescaler, counter and output divider
`timescale 1ns/1ps

`include "timer_map.svh"

module timer_control_registers
    import timer_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    input wire logic aclk, // System clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic pin_clk_in, // Count pin, external
    input wire logic [4:0] osc_clk_in, // Sources for codes 3 to 7
    output logic timer_toggle_output, // Divided timer output level
    output logic irq // Level interrupt
);

    initial begin
        if (ADDR_W < 14 || ADDR_W > 32) begin
            $error("timer_control_registers: ADDR_W out of range");
        end
    end

    // Word index of a byte address, used by both channels
    function automatic logic [`IDX_W-1:0] word_idx(
        input logic [ADDR_W-1:0] a
    );
        word_idx = a[`IDX_W+1:2];
    endfunction

    // ==========================================================
    // Register state
    logic run_q;
    logic wide_q;
    logic [3:0] div_sel_q;
    logic [7:0] ctrl1_q;
    logic [7:0] cnt_lo_q;
    logic [7:0] cnt_hi_q;
    logic [7:0] hreg_q;
    logic [7:0] hbuf_q;
    logic status_q;
    logic mask_q;
    logic out_q;
    logic irq_q;

    // ==========================================================
    // AXI4-Lite write channel
    logic aw_held_q;
    logic w_held_q;
    logic [`IDX_W-1:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
    wire w_take = s_axi_wvalid && !w_held_q && !bvalid_q;
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire wr_lane = wstrb_q[0];

    // Write decode, only with the low byte lane strobed
    wire wr_lo = wr_fire && wr_lane && aw_idx_q == `IDX_COUNT_LOW;
    wire wr_hi = wr_fire && wr_lane && aw_idx_q == `IDX_COUNT_HIGH;
    wire wr_c0 = wr_fire && wr_lane && aw_idx_q == `IDX_CTRL_ZERO;
    wire wr_c1 = wr_fire && wr_lane && aw_idx_q == `IDX_CTRL_ONE;
    wire wr_st = wr_fire && wr_lane && aw_idx_q == `IDX_IRQ_STATUS;
    wire wr_mk = wr_fire && wr_lane && aw_idx_q == `IDX_IRQ_MASK;
    wire wr_mapped = aw_idx_q >= `IDX_COUNT_LOW
        && aw_idx_q <= `IDX_IRQ_MASK;
    wire [7:0] wbyte = wdata_q[7:0];

    // Address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_idx_q <= word_idx(s_axi_awaddr);
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Ready flags come from flops fed by the next hold state
    logic awready_q;
    logic wready_q;
    wire aw_held_d = aw_take || (aw_held_q && !wr_fire);
    wire w_held_d = w_take || (w_held_q && !wr_fire);
    wire bvalid_d = wr_fire || (bvalid_q && !s_axi_bready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            awready_q <= !aw_held_d && !bvalid_d;
            wready_q <= !w_held_d && !bvalid_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ==========================================================
    // AXI4-Lite read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire ar_take = s_axi_arvalid && !rvalid_q;
    wire [`IDX_W-1:0] ar_idx = word_idx(s_axi_araddr);
    wire rd_lo = ar_take && ar_idx == `IDX_COUNT_LOW;
    wire rd_ok = ar_idx >= `IDX_COUNT_LOW && ar_idx <= `IDX_IRQ_MASK;
    wire [7:0] ctrl0_view = {run_q, 1'b0, out_q, wide_q, div_sel_q};

    // Read mux; bits above the byte read as zero
    logic [7:0] rbyte;
    always_comb begin
        case (ar_idx)
            `IDX_COUNT_LOW: rbyte = cnt_lo_q;
            `IDX_COUNT_HIGH: rbyte = hreg_q;
            `IDX_CTRL_ZERO: rbyte = ctrl0_view;
            `IDX_CTRL_ONE: rbyte = ctrl1_q;
            `IDX_IRQ_STATUS: rbyte = {7'h00, status_q};
            `IDX_IRQ_MASK: rbyte = {7'h00, mask_q};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rbyte};
            rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Registered so that the output comes straight from a flop
    logic arready_q;
    wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
        end else begin
            arready_q <= !rvalid_d;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ==========================================================
    // Source selection and edge detection
    logic [5:0] ext_lvl;
    logic [1:0] phase_q;
    logic sel_prev_q;

    input_filter #(
        .W(6)
    ) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw_in({osc_clk_in, pin_clk_in}),
        .level_out(ext_lvl)
    );

    // Instruction clock runs at a quarter of the system rate
    wire instr_tick = phase_q == `INSTR_LAST;
    wire instr_lvl = phase_q[1];
    wire bypass = ctrl1_q[`C1_BYPASS_BIT];
    wire [3:0] pre_sel = ctrl1_q[`C1_PRE_MSB:`C1_PRE_LSB];
    count_src_t src_sel;
    assign src_sel = count_src_t'(ctrl1_q[`C1_SRC_MSB:`C1_SRC_LSB]);

    logic sel_lvl;
    always_comb begin
        case (src_sel)
            SRC_PIN: sel_lvl = ext_lvl[0];
            SRC_PIN_INV: sel_lvl = !ext_lvl[0];
            SRC_INSTR: sel_lvl = instr_lvl;
            SRC_OSC_A: sel_lvl = ext_lvl[1];
            SRC_OSC_B: sel_lvl = ext_lvl[2];
            SRC_OSC_C: sel_lvl = ext_lvl[3];
            SRC_OSC_D: sel_lvl = ext_lvl[4];
            SRC_LOGIC: sel_lvl = ext_lvl[5];
            default: sel_lvl = 1'b0;
        endcase
    end

    wire src_edge = sel_lvl && !sel_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 2'h0;
            sel_prev_q <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            sel_prev_q <= sel_lvl;
        end
    end

    // ==========================================================
    // Prescaler, sync alignment and output divider
    logic [`PRE_CNT_W-1:0] pre_cnt_q;
    logic pend_q;
    logic [3:0] post_q;

    // Any control or low byte write restarts both dividers
    wire div_clear = wr_c0 || wr_c1 || wr_lo;
    wire ctl_write = div_clear || wr_hi;
    // Terminal prescaler value is two to the field, minus one
    wire [`PRE_CNT_W-1:0] pre_last =
        `PRE_CNT_W'((32'h1 << pre_sel) - 32'h1);
    wire pre_tick = run_q && !ctl_write && src_edge
        && pre_cnt_q == pre_last;
    // Sync mode waits for the quarter-rate tick; bypass does not
    wire cnt_tick = bypass ? pre_tick
        : (pend_q && instr_tick && run_q && !ctl_write);

    always_ff @(posedge aclk) begin
        if (!aresetn || div_clear) begin
            pre_cnt_q <= '0;
            pend_q <= 1'b0;
        end else if (run_q && src_edge) begin
            pre_cnt_q <= pre_tick ? '0 : pre_cnt_q + 1'b1;
            pend_q <= pre_tick || (pend_q && !cnt_tick);
        end else begin
            pend_q <= pend_q && !cnt_tick;
        end
    end

    // ==========================================================
    // Counter datapath
    wire lo_match = cnt_lo_q == hbuf_q;
    wire full16 = {cnt_hi_q, cnt_lo_q} == 16'hFFFF;
    wire period_evt = cnt_tick && (wide_q ? full16 : lo_match);
    wire [15:0] cnt_inc = {cnt_hi_q, cnt_lo_q} + 16'h0001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_lo_q <= `COUNT_RESET;
            cnt_hi_q <= `COUNT_RESET;
            hbuf_q <= `COUNT_RESET;
        end else if (wr_lo) begin
            cnt_lo_q <= wbyte;
            cnt_hi_q <= hreg_q;
            hbuf_q <= hreg_q;
        end else if (cnt_tick && wide_q) begin
            cnt_lo_q <= cnt_inc[7:0];
            cnt_hi_q <= cnt_inc[15:8];
        end else if (cnt_tick && lo_match) begin
            cnt_lo_q <= 8'h00;
            hbuf_q <= hreg_q;
        end else if (cnt_tick) begin
            cnt_lo_q <= cnt_lo_q + 8'h01;
        end
    end

    // High byte register: written by software, latched on low read in wide mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hreg_q <= `COUNT_RESET;
        end else if (wr_hi) begin
            hreg_q <= wbyte;
        end else if (rd_lo && wide_q) begin
            hreg_q <= cnt_hi_q;
        end
    end

    // Divider counts events; terminal count toggles the output
    wire post_done = period_evt && post_q == div_sel_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || div_clear) begin
            post_q <= 4'h0;
        end else if (period_evt) begin
            post_q <= post_done ? 4'h0 : post_q + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= 1'b0;
        end else if (post_done) begin
            out_q <= !out_q;
        end
    end

    // ==========================================================
    // Control registers; output bit and bit 6 are not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            wide_q <= 1'b0;
            div_sel_q <= 4'h0;
            ctrl1_q <= `CTRL_RESET;
        end else begin
            if (wr_c0) begin
                run_q <= wbyte[`C0_RUN_BIT];
                wide_q <= wbyte[`C0_WIDE_BIT];
                div_sel_q <= wbyte[`C0_DIV_MSB:`C0_DIV_LSB];
            end
            if (wr_c1) begin
                ctrl1_q <= wbyte;
            end
        end
    end

    // ==========================================================
    // Interrupt: set beats a same-cycle write-one clear
    wire status_d = post_done || (status_q && !(wr_st && wbyte[0]));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= 1'b0;
            mask_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (wr_mk) begin
                mask_q <= wbyte[0];
            end
            irq_q <= status_d && (wr_mk ? wbyte[0] : mask_q);
        end
    end

    assign timer_toggle_output = out_q;
    assign irq = irq_q;

    // ==========================================================
    // Assertions
    chk_idle_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        !run_q && !wr_lo |=> $stable(cnt_lo_q) && $stable(cnt_hi_q))
        else $error("Counter moved while disabled");
    chk_out_readonly: assert property (@(posedge aclk)
        disable iff (!aresetn) wr_c0 |=> $stable(out_q))
        else $error("Control write changed output");
    chk_wide_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_tick && wide_q && full16 && !wr_lo
        |=> {cnt_hi_q, cnt_lo_q} == 16'h0000)
        else $error("16-bit counter did not wrap");
    chk_byte_match: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_tick && !wide_q && lo_match && !wr_lo
        |=> cnt_lo_q == 8'h00 && hbuf_q == $past(hreg_q))
        else $error("8-bit match did not clear and reload");
    chk_div_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(out_q) |-> $past(post_q) == $past(div_sel_q))
        else $error("Output toggled off divider count");
    chk_flag_toggle: assert property (@(posedge aclk)
        disable iff (!aresetn) $changed(out_q) |-> status_q)
        else $error("Toggle without interrupt flag");
    chk_pre_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
        pre_tick |-> pre_cnt_q == pre_last && src_edge)
        else $error("Prescaler ticked early");
    chk_div_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        div_clear |=> pre_cnt_q == '0 && post_q == 4'h0)
        else $error("Dividers not cleared by write");
    chk_sync_align: assert property (@(posedge aclk)
        disable iff (!aresetn)
        cnt_tick && !bypass |-> phase_q == `INSTR_LAST)
        else $error("Synchronous count off instruction tick");
    chk_bit6_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && ar_idx == `IDX_CTRL_ZERO |=> !s_axi_rdata[6])
        else $error("Unimplemented bit read as one");
    cov_byte_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
        post_done && !wide_q);
    cov_wide_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
        period_evt && wide_q);
    cov_irq_raise: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq_q));

endmodule

// *** testbench/test_timer_control_registers.sv ***
// Self-checking bench for the timer control registers
`timescale 1ns/1ps
`include "timer_map.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module test_timer_control_registers
    import timer_pkg::*;
;
    logic aclk, aresetn;
    logic [13:0] aw_addr, ar_addr;
    logic aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [31:0] w_data, r_data, rv;
    logic [3:0] w_strb, slow_cnt;
    logic [1:0] b_resp, r_resp, rr;
    logic pin_clk_in, pin_en, tog, irq;
    logic [4:0] osc_clk_in, osc_en;
    int failures, total_checks, n;

    timer_control_registers timer_control_registers_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
        .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
        .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .pin_clk_in(pin_clk_in),
        .osc_clk_in(osc_clk_in), .timer_toggle_output(tog), .irq(irq)
    );

    // ==========================================================
    // Clock and slow source: 16-cycle period, gated per source
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        slow_cnt <= slow_cnt + 4'h1;
        pin_clk_in <= pin_en & slow_cnt[3];
        osc_clk_in <= osc_en & {5{slow_cnt[3]}};
    end

    // ==========================================================
    // Reporting
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // A hung wait counts as a mismatch and ends the run
    task automatic give_up();
        failures++;
        $display("[ERR] t=%0t wait limit got=%h exp=%h", $time, 0, 1);
        stop_test();
    endtask

    // ==========================================================
    // Bus tasks; address and data are released only when taken
    task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        int k;
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        k = 0;
        aw_addr <= {idx, 2'b00};
        aw_valid <= 1'b1;
        w_data <= {24'h0, d};
        w_strb <= 4'hF;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        while (1) begin
            @(posedge aclk);
            if (!ad && aw_ready) begin
                ad = 1'b1;
                aw_valid <= 1'b0;
            end
            if (!wd && w_ready) begin
                wd = 1'b1;
                w_valid <= 1'b0;
            end
            if (b_valid) begin
                `CHK(b_resp, er);
                b_ready <= 1'b0;
                break;
            end
            k++;
            if (k > 200) give_up();
        end
    endtask

    task automatic rd(input logic [11:0] idx, output logic [31:0] v,
                      output logic [1:0] r);
        int k;
        logic ad;
        ad = 1'b0;
        k = 0;
        ar_addr <= {idx, 2'b00};
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        while (1) begin
            @(posedge aclk);
            if (!ad && ar_ready) begin
                ad = 1'b1;
                ar_valid <= 1'b0;
            end
            if (r_valid) begin
                v = r_data;
                r = r_resp;
                r_ready <= 1'b0;
                break;
            end
            k++;
            if (k > 200) give_up();
        end
    endtask

    task automatic rdc(input logic [11:0] idx, input logic [7:0] e,
                       input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] r;
        rd(idx, v, r);
        `CHK(v, {24'h0, e});
        `CHK(r, er);
    endtask

    // Cycles until the output level next changes
    task automatic wait_tog(output int k);
        logic last;
        k = 0;
        last = tog;
        while (tog === last) begin
            @(posedge aclk);
            k++;
            if (k > 2000) give_up();
        end
    endtask

    // Skip one toggle, then time the next interval
    task automatic meas(input int e);
        int k;
        wait_tog(k);
        wait_tog(k);
        `CHK(k, e);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {aw_addr, ar_addr, aw_valid, w_valid, b_ready} = '0;
        {ar_valid, r_ready, w_data, w_strb} = '0;
        {slow_cnt, pin_clk_in, pin_en, osc_clk_in, osc_en} = '0;
        failures = 0;
        total_checks = 0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(`IDX_CTRL_ZERO, `CTRL_RESET, `RESP_OKAY);
        rdc(`IDX_CTRL_ONE, `CTRL_RESET, `RESP_OKAY);
        wr(`IDX_CTRL_ZERO, 8'h6F, `RESP_OKAY);
        rdc(`IDX_CTRL_ZERO, 8'h0F, `RESP_OKAY);
        wr(`IDX_CTRL_ONE, 8'hB7, `RESP_OKAY);
        rdc(`IDX_CTRL_ONE, 8'hB7, `RESP_OKAY);
        wr(12'h000, 8'h55, `RESP_SLVERR);
        rdc(12'h000, 8'h00, `RESP_SLVERR);
        // Stopped timer: nothing moves
        wr(`IDX_CTRL_ONE, {SRC_INSTR, 5'h00}, `RESP_OKAY);
        wr(`IDX_COUNT_HIGH, 8'h01, `RESP_OKAY);
        wr(`IDX_COUNT_LOW, 8'h00, `RESP_OKAY);
        wr(`IDX_CTRL_ZERO, 8'h00, `RESP_OKAY);
        repeat (100) @(posedge aclk);
        `CHK(tog, 1'b0);
        rdc(`IDX_COUNT_LOW, 8'h00, `RESP_OKAY);
        // Period 1 is two ticks of four cycles, times divider field plus one
        for (int d = 0; d < 16; d += 5) begin
            wr(`IDX_CTRL_ZERO, 8'h80 | 8'(d), `RESP_OKAY);
            meas(8 * (d + 1));
        end
        // Clearing the divider mid-way restarts the full interval
        wr(`IDX_CTRL_ZERO, 8'h81, `RESP_OKAY);
        wait_tog(n);
        repeat (8) @(posedge aclk);
        wr(`IDX_COUNT_LOW, 8'h00, `RESP_OKAY);
        wait_tog(n);
        `CHK(n > 11, 1'b1);
        wr(`IDX_COUNT_HIGH, 8'h03, `RESP_OKAY);
        wr(`IDX_CTRL_ZERO, 8'h80, `RESP_OKAY);
        wr(`IDX_COUNT_LOW, 8'h00, `RESP_OKAY);
        meas(16);
        wr(`IDX_COUNT_HIGH, 8'h01, `RESP_OKAY);
        wr(`IDX_COUNT_LOW, 8'h00, `RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            wr(`IDX_CTRL_ONE, {SRC_INSTR, 1'b0, 4'(k)}, `RESP_OKAY);
            meas(8 << k);
        end
        // Each other source alone, bypassing the instruction-tick alignment
        for (int s = 0; s < 8; s++) begin
            if (s != 2) begin
                pin_en <= (s < 2);
                osc_en <= (s > 2) ? 5'(1 << (s - 3)) : 5'h00;
                wr(`IDX_CTRL_ONE, {3'(s), 1'b1, 4'h0}, `RESP_OKAY);
                meas(32);
            end
        end
        // Wide mode: load FFF0 through the high buffer, wrap after 16
        wr(`IDX_CTRL_ZERO, 8'h10, `RESP_OKAY);
        wr(`IDX_CTRL_ONE, {SRC_INSTR, 5'h00}, `RESP_OKAY);
        wr(`IDX_COUNT_HIGH, 8'hFF, `RESP_OKAY);
        wr(`IDX_COUNT_LOW, 8'hF0, `RESP_OKAY);
        rdc(`IDX_COUNT_LOW, 8'hF0, `RESP_OKAY);
        rdc(`IDX_COUNT_HIGH, 8'hFF, `RESP_OKAY);
        wr(`IDX_CTRL_ZERO, 8'h90, `RESP_OKAY);
        wait_tog(n);
        `CHK(n >= 56 && n <= 72, 1'b1);
        wr(`IDX_CTRL_ZERO, 8'h10, `RESP_OKAY);
        rd(`IDX_COUNT_LOW, rv, rr);
        rdc(`IDX_COUNT_HIGH, 8'h00, `RESP_OKAY);
        // Output level bit follows the pin and ignores writes
        rd(`IDX_CTRL_ZERO, rv, rr);
        `CHK(rv[5], tog);
        wr(`IDX_CTRL_ZERO, {2'b00, ~tog, 5'h10}, `RESP_OKAY);
        rd(`IDX_CTRL_ZERO, rv, rr);
        `CHK(rv[5], tog);
        // Interrupt: sticky status, mask, write one to clear
        rdc(`IDX_IRQ_STATUS, 8'h01, `RESP_OKAY);
        `CHK(irq, 1'b0);
        wr(`IDX_IRQ_MASK, 8'h01, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1);
        wr(`IDX_IRQ_STATUS, 8'h01, `RESP_OKAY);
        rdc(`IDX_IRQ_STATUS, 8'h00, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0);
        stop_test();
    end
endmodule
